/* include/bolt_pkg.sv */
// package for the locking bolt control: states, register map, timing
// assumes a 25 MHz pclk and an APB master of 32-bit data
//
// Notes on behaviour
// - both inputs high with c low unlocks, open locks
// - same decoding whatever supply variant present
// - failed lock drive retried once autonomously
// - second failure enters fault, shown on diagnostics
// - after fault, inputs must change first
// - locked at power-on needs unlock then lock
// - yellow flashes while awaiting initial unlock
// - safety outputs periodically switched off briefly
// - supplies at init: aux retracts, both fault
// - active manual release flashes all three LEDs
package bolt_pkg;
    // register byte offsets
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] EVENT_OFS  = 12'h008;
    localparam logic [11:0] MASK_OFS   = 12'h00C;
    // reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [3:0]  MASK_RST   = 4'h0;
    // event bit positions
    localparam int EV_LOCKED = 0;
    localparam int EV_UNLOCK = 1;
    localparam int EV_RETRY  = 2;
    localparam int EV_FAULT  = 3;
    // timing, in their own units
    localparam int CLK_HZ         = 25_000_000;
    localparam int TEST_PULSE_NS  = 400;          // off-pulse, well in limit
    localparam int TEST_PERIOD_US = 1000;         // pulse spacing
    localparam int DRIVE_US       = 200_000;      // bolt move timeout
    localparam int FLASH_US       = 250_000;      // half flash period
    // cycle counts: integer division, so every count rounds down
    localparam int TEST_PULSE_CYC = TEST_PULSE_NS * (CLK_HZ / 1_000_000)
                                    / 1000;
    localparam int TEST_PERIOD_CYC = TEST_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int DRIVE_CYC = DRIVE_US * (CLK_HZ / 1_000_000);
    localparam int FLASH_CYC = FLASH_US * (CLK_HZ / 1_000_000);

    typedef enum {
        ST_INIT, ST_WAIT_UNLOCK, ST_UNLOCKING, ST_UNLOCKED, ST_LOCKING,
        ST_LOCKED, ST_FAULT, ST_AUX_RELEASE
    } bolt_state_e;

    // pins that leave the block together
    typedef struct packed {
        logic yellow;
        logic green;
        logic red;
    } leds_s;
endpackage

/* rtl/sync2.sv */
// two-flop synchroniser for asynchronous pin levels
// assumes nothing but the pclk domain
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic d,
    output var  logic q
);
    logic meta_reg;   // first stage, read only by q
    // two stages, reset to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // sync2
`default_nettype wire

/* rtl/test_pulser.sv */
// safety output driver with periodic test off-pulses
// assumes pclk 25 MHz; enable comes from the main state machine
`timescale 1ns/1ps
`default_nettype none
module test_pulser #(
    parameter int PERIOD = bolt_pkg::TEST_PERIOD_CYC,
    parameter int PULSE  = bolt_pkg::TEST_PULSE_CYC,
    parameter int OFFSET = 0
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic enable,
    output var  logic out
);
    logic [19:0] cnt_reg;   // period counter
    // count the period; the two channels use different offsets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 20'h0_0000;
        end else if (cnt_reg == 20'(PERIOD - 1)) begin
            cnt_reg <= 20'h0_0000;
        end else begin
            cnt_reg <= cnt_reg + 20'h0_0001;
        end
    end
    // output low during the pulse window so the wiring is exercised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out <= 1'b0;
        end else begin
            out <= enable && !((cnt_reg >= 20'(OFFSET)) &&
                   (cnt_reg < 20'(OFFSET + PULSE)));
        end
    end
    // an off-pulse never exceeds its window
    logic [19:0] low_cnt;   // helper: length of running off-pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 20'h0_0000;
        end else begin
            low_cnt <= (enable && !out) ? low_cnt + 20'h0_0001 : 20'h0_0000;
        end
    end
    a_pulse_short : assert property (@(posedge pclk) disable iff (!presetn)
        $past(enable) && enable |-> low_cnt <= 20'(PULSE + 1))
        else $error("test off-pulse too long");
endmodule // test_pulser
`default_nettype wire

/* rtl/locking_bolt_control.sv */
// locking bolt control with APB status/control registers
// assumes pins asynchronous to pclk; bolt sensors are plain levels
`timescale 1ns/1ps
`default_nettype none
module locking_bolt_control #(
    parameter int DRIVE_CYC = bolt_pkg::DRIVE_CYC,
    parameter int FLASH_CYC = bolt_pkg::FLASH_CYC
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          control_in_a,
    input  wire logic          control_in_b,
    input  wire logic          control_in_c,
    input  wire logic          main_supply_in,
    input  wire logic          aux_supply_in,
    input  wire logic          bolt_locked_in,
    input  wire logic          bolt_open_in,
    input  wire logic          release_active_in,
    output var  logic          bolt_extend,
    output var  logic          bolt_retract,
    output logic               safety_out_a,
    output logic               safety_out_b,
    output var  logic          diag_out_first,
    output var  logic          diag_out_second,
    output var  bolt_pkg::leds_s leds,
    output logic               irq
);
    import bolt_pkg::*;

    // synchronised pin levels
    logic in_a, in_b, in_c, sup_main, sup_aux, s_locked, s_open, s_rel;
    sync2 u_sa (.pclk(pclk), .presetn(presetn), .d(control_in_a),
                .q(in_a));
    sync2 u_sb (.pclk(pclk), .presetn(presetn), .d(control_in_b),
                .q(in_b));
    sync2 u_sc (.pclk(pclk), .presetn(presetn), .d(control_in_c),
                .q(in_c));
    sync2 u_sm (.pclk(pclk), .presetn(presetn), .d(main_supply_in),
                .q(sup_main));
    sync2 u_sx (.pclk(pclk), .presetn(presetn), .d(aux_supply_in),
                .q(sup_aux));
    sync2 u_sl (.pclk(pclk), .presetn(presetn), .d(bolt_locked_in),
                .q(s_locked));
    sync2 u_so (.pclk(pclk), .presetn(presetn), .d(bolt_open_in),
                .q(s_open));
    sync2 u_sr (.pclk(pclk), .presetn(presetn), .d(release_active_in),
                .q(s_rel));

    // unlock demand: a and b both driven; c open only in lock (P/N);
    // grounded c reads as 0 in both variants, so one decode serves
    logic unlock_cmd;
    assign unlock_cmd = in_a && in_b && !in_c;

    // control register: bit0 blocks command moves out of ST_WAIT_UNLOCK, ST_UNLOCKED and ST_LOCKED (software inhibit)
    logic [31:0] ctrl_reg;
    logic        inhibit;
    assign inhibit = ctrl_reg[0];

    bolt_state_e state_reg;     // main state
    logic [23:0] tmr_reg;       // drive timeout
    logic        retry_reg;     // second attempt in progress
    logic        fault_cmd_reg; // command captured at fault
    logic        prev_cmd_reg;  // unused; the fault compare uses fault_cmd_reg
    logic        startup_reg;   // set one cycle after reset, enables the init sample
    logic [3:0]  ev_set;        // one-cycle event pulses
    logic        timeout;
    assign timeout = (tmr_reg == 24'(DRIVE_CYC - 1));

    // main bolt state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg     <= ST_INIT;
            retry_reg     <= 1'b0;
            fault_cmd_reg <= 1'b0;
            startup_reg   <= 1'b0;
        end else begin
            startup_reg <= 1'b1;
            case (state_reg)
                ST_INIT: begin
                    // wait one cycle after reset before sampling; INIT loops while sup_main and sup_aux both read 0
                    if (startup_reg) begin
                        if (sup_aux && !sup_main) begin
                            state_reg <= ST_AUX_RELEASE;
                        end else if (sup_aux && sup_main) begin
                            state_reg <= ST_FAULT;
                            fault_cmd_reg <= unlock_cmd;
                        end else if (!sup_main) begin
                            state_reg <= ST_INIT;
                        end else if (s_locked) begin
                            state_reg <= ST_WAIT_UNLOCK;
                        end else begin
                            state_reg <= ST_UNLOCKED;
                        end
                    end
                end
                ST_WAIT_UNLOCK: begin
                    if (unlock_cmd && !inhibit) begin
                        state_reg <= ST_UNLOCKING;
                    end
                end
                ST_AUX_RELEASE: begin
                    state_reg <= ST_AUX_RELEASE;
                end
                ST_UNLOCKING: begin
                    if (s_open) begin
                        state_reg <= ST_UNLOCKED;
                    end else if (timeout) begin
                        state_reg     <= ST_FAULT;
                        fault_cmd_reg <= unlock_cmd;
                    end
                end
                ST_UNLOCKED: begin
                    if (!unlock_cmd && !inhibit) begin
                        state_reg <= ST_LOCKING;
                        retry_reg <= 1'b0;
                    end
                end
                ST_LOCKING: begin
                    if (unlock_cmd) begin
                        state_reg <= ST_UNLOCKING;
                    end else if (s_locked) begin
                        state_reg <= ST_LOCKED;
                    end else if (timeout && !retry_reg) begin
                        retry_reg <= 1'b1;
                    end else if (timeout) begin
                        state_reg     <= ST_FAULT;
                        fault_cmd_reg <= unlock_cmd;
                    end
                end
                ST_LOCKED: begin
                    if (unlock_cmd && !inhibit) begin
                        state_reg <= ST_UNLOCKING;
                    end else if (!s_locked) begin
                        state_reg <= ST_LOCKING;
                        retry_reg <= 1'b0;
                    end
                end
                ST_FAULT: begin
                    // only a change of the inputs releases the fault
                    if (sup_main && !sup_aux &&
                        unlock_cmd != fault_cmd_reg) begin
                        state_reg <= unlock_cmd ? ST_UNLOCKING
                                                : ST_LOCKING;
                        retry_reg <= 1'b0;
                    end
                end
                default: state_reg <= ST_INIT;
            endcase
        end
    end

    // drive timer restarts on each attempt, including the retry, but not on an unlock that interrupts ST_LOCKING
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_reg <= 24'h00_0000;
        end else if ((state_reg == ST_LOCKING ||
                      state_reg == ST_UNLOCKING) && !timeout) begin
            tmr_reg <= tmr_reg + 24'h00_0001;
        end else begin
            tmr_reg <= 24'h00_0000;
        end
    end

    // bolt drive outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bolt_extend  <= 1'b0;
            bolt_retract <= 1'b0;
        end else begin
            bolt_extend  <= (state_reg == ST_LOCKING) && !timeout;
            bolt_retract <= (state_reg == ST_UNLOCKING) ||
                            (state_reg == ST_AUX_RELEASE);
        end
    end

    // safety outputs: only when confirmed locked and fault free
    logic safe_en;
    assign safe_en = (state_reg == ST_LOCKED) && s_locked;
    test_pulser #(.OFFSET(0)) u_pa (.pclk(pclk), .presetn(presetn),
        .enable(safe_en), .out(safety_out_a));
    test_pulser #(.OFFSET(100)) u_pb (.pclk(pclk), .presetn(presetn),
        .enable(safe_en), .out(safety_out_b));

    // flash timebase
    logic [23:0] flash_cnt_reg;
    logic        flash_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt_reg <= 24'h00_0000;
            flash_reg     <= 1'b0;
        end else if (flash_cnt_reg == 24'(FLASH_CYC - 1)) begin
            flash_cnt_reg <= 24'h00_0000;
            flash_reg     <= !flash_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 24'h00_0001;
        end
    end

    // release indication latched until the inputs are driven again
    logic rel_ind_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rel_ind_reg <= 1'b0;
        end else if (s_rel) begin
            rel_ind_reg <= 1'b1;
        end else if (in_a || in_b) begin
            rel_ind_reg <= 1'b0;
        end
    end

    // indicators and diagnostic outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leds            <= '0;
            diag_out_first  <= 1'b0;
            diag_out_second <= 1'b0;
        end else begin
            if (rel_ind_reg) begin
                leds <= '{yellow: flash_reg, green: flash_reg,
                          red: flash_reg};
            end else begin
                leds.yellow <= (state_reg == ST_WAIT_UNLOCK) ? flash_reg
                             : (state_reg == ST_LOCKED);
                leds.green  <= (state_reg != ST_FAULT);
                leds.red    <= (state_reg == ST_FAULT);
            end
            diag_out_first  <= (state_reg == ST_LOCKED);
            diag_out_second <= (state_reg == ST_FAULT);
        end
    end

    // events, one cycle each
    always_comb begin
        ev_set = 4'h0;
        ev_set[EV_LOCKED] = (state_reg == ST_LOCKING) && s_locked;
        ev_set[EV_UNLOCK] = (state_reg == ST_UNLOCKING) && s_open;
        ev_set[EV_RETRY]  = (state_reg == ST_LOCKING) && timeout &&
                            !retry_reg && !s_locked && !unlock_cmd;
        ev_set[EV_FAULT]  = timeout && ((state_reg == ST_UNLOCKING &&
                            !s_open) || (state_reg == ST_LOCKING &&
                            retry_reg && !s_locked && !unlock_cmd));
    end

    // APB: zero wait states, no error on unmapped (reads zero)
    logic        wr_en, rd_en;
    logic [3:0]  event_reg, mask_reg;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // control and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            mask_reg <= MASK_RST;
        end else if (wr_en && paddr == CTRL_OFS) begin
            ctrl_reg <= {31'h0000_0000, pwdata[0]};
        end else if (wr_en && paddr == MASK_OFS) begin
            mask_reg <= pwdata[3:0];
        end
    end

    // sticky events: read clears, a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_reg <= 4'h0;
        end else if (rd_en && paddr == EVENT_OFS) begin
            event_reg <= ev_set;
        end else begin
            event_reg <= event_reg | ev_set;
        end
    end
    assign irq = |(event_reg & mask_reg);

    // read data mux
    always_comb begin
        case (paddr)
            CTRL_OFS:   prdata = ctrl_reg;
            STATUS_OFS: prdata = {20'h0_0000, 3'(unsigned'(state_reg)),
                                  retry_reg, in_a, in_b, in_c, s_locked,
                                  s_open, sup_main, sup_aux, s_rel};
            EVENT_OFS:  prdata = {28'h000_0000, event_reg};
            MASK_OFS:   prdata = {28'h000_0000, mask_reg};
            default:    prdata = 32'h0000_0000;
        endcase
    end

    // assertions
    a_safe_off_unlocked : assert property (@(posedge pclk)
        disable iff (!presetn)
        (state_reg != ST_LOCKED) |=> !safety_out_a && !safety_out_b)
        else $error("safety outputs on while not locked");
    a_fault_diag : assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_FAULT && !rel_ind_reg
        |=> diag_out_second && leds.red)
        else $error("fault not shown");
    a_fault_holds : assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_FAULT && unlock_cmd == fault_cmd_reg
        |=> state_reg == ST_FAULT)
        else $error("fault left without input change");
    a_fault_no_drive : assert property (@(posedge pclk)
        disable iff (!presetn)
        state_reg == ST_FAULT ##1 state_reg == ST_FAULT |=> !bolt_extend)
        else $error("bolt driven during fault");
    a_retry_once : assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_LOCKING && timeout && !retry_reg && !unlock_cmd
        && !s_locked |=> state_reg == ST_LOCKING && retry_reg)
        else $error("no second lock attempt");
    a_second_fail : assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_LOCKING && timeout && retry_reg && !unlock_cmd
        && !s_locked |=> state_reg == ST_FAULT)
        else $error("second failure not faulted");
    a_wait_unlock : assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_WAIT_UNLOCK && !unlock_cmd
        |=> state_reg == ST_WAIT_UNLOCK)
        else $error("power-on lock accepted early");
    a_unlock_decode : assert property (@(posedge pclk)
        disable iff (!presetn)
        state_reg == ST_LOCKED && in_a && in_b && !in_c && !inhibit
        |=> state_reg == ST_UNLOCKING)
        else $error("unlock command ignored");
    a_aux_retract : assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_AUX_RELEASE |=> bolt_retract)
        else $error("aux release not retracting");
    a_yellow_flash : assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_WAIT_UNLOCK && !rel_ind_reg
        |=> leds.yellow == $past(flash_reg))
        else $error("yellow not flashing");
endmodule // locking_bolt_control
`default_nettype wire

/* verif/bolt_plant.sv */
// far side model: bolt mechanics plus the dual-channel off-pulse monitor
// assumes the bench clock; bolt sits driven out at power-on
`timescale 1ns/1ps
`default_nettype none
module bolt_plant #(
    parameter int MOVE = 6
) (
    input  wire logic pclk,
    input  wire logic extend,
    input  wire logic retract,
    input  wire logic jam,
    input  wire logic arm,
    input  wire logic safe_a,
    input  wire logic safe_b,
    output var  logic locked,
    output var  logic open,
    output var  int   max_off,
    output var  int   pulses,
    output var  int   max_skew
);
    int pos = MOVE;  // mechanics keep position through any reset
    int run_a = 0;   // current low run, channel a
    int run_b = 0;   // current low run, channel b
    initial max_off = 0;
    initial pulses = 0;
    int skew = 0;    // current run of the two channels disagreeing
    initial max_skew = 0;
    // channel discrepancy must stay inside the monitor's window
    always @(posedge pclk) begin
        skew <= (arm && safe_a != safe_b) ? skew + 1 : 0;
        if (skew > max_skew) max_skew <= skew;
    end
    // one step a cycle; a jam stops the bolt short of the locked end
    always @(posedge pclk) begin
        if (extend && pos < MOVE - (jam ? 2 : 0)) pos <= pos + 1;
        else if (retract && pos > 0) pos <= pos - 1;
    end
    assign locked = (pos == MOVE);
    assign open = (pos == 0);
    // monitor takes two positive-switching channels, blanks off-pulses
    always @(posedge pclk) begin
        run_a <= (arm && !safe_a) ? run_a + 1 : 0;
        run_b <= (arm && !safe_b) ? run_b + 1 : 0;
        if (run_a > max_off) max_off <= run_a;
        if (run_b > max_off) max_off <= run_b;
        if (arm && !safe_a && run_a == 0) pulses <= pulses + 1;
        if (arm && !safe_b && run_b == 0) pulses <= pulses + 1;
    end
endmodule // bolt_plant
`default_nettype wire

/* verif/locking_bolt_control_tb.sv */
// self-checking bench for the locking bolt control
// assumes bolt_plant as far side; short drive and flash parameters
`timescale 1ns/1ps
`default_nettype none
module locking_bolt_control_tb;
    import bolt_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic ca, cb, cc, ext, ret, lk, opn, sa, sb, d1, d2, irq, jam, arm, y;
    logic mn, ax, rl;           // supply and release pins
    leds_s leds;
    int max_off, pulses, tog, rises, n, max_skew;
    localparam int OFF_LIM_CYC = 10_000;    // 0.4 ms tolerated off-pulse
    localparam int DISC_CYC = 2_500_000;    // 100 ms channel discrepancy
    int err_count = 0;
    int samples_checked = 0;
    int seed = 32'h018c7535;   // fixed seed keeps runs repeatable
    int ev_exp;                 // model of sticky event bits
    logic [3:0] m;              // random interrupt mask
    always #20 pclk = ~pclk;
    locking_bolt_control #(.DRIVE_CYC(50), .FLASH_CYC(20))
    locking_bolt_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .control_in_a(ca), .control_in_b(cb), .control_in_c(cc),
        .main_supply_in(mn), .aux_supply_in(ax), .bolt_locked_in(lk),
        .bolt_open_in(opn), .release_active_in(rl), .bolt_extend(ext),
        .bolt_retract(ret), .safety_out_a(sa), .safety_out_b(sb),
        .diag_out_first(d1), .diag_out_second(d2), .leds(leds), .irq(irq));
    bolt_plant bolt_plant_i (.pclk(pclk), .extend(ext), .retract(ret),
        .jam(jam), .arm(arm), .safe_a(sa), .safe_b(sb), .locked(lk),
        .open(opn), .max_off(max_off), .pulses(pulses), .max_skew(max_skew));
    // verdict and the single place the run ends
    task end_of_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded wait for a level; a hang ends the run
    task automatic wt(ref logic s, input logic v);
        int k;
        k = 0;
        while (s !== v && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 2000) begin
            err_count++;
            $display("ERROR %0t wait ran out", $time);
            end_of_test();
        end
    endtask
    // apb transfer: setup, access until pready, then release
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            err_count++;
            $display("ERROR %0t no pready", $time);
            end_of_test();
        end
        @(posedge pclk);
    endtask
    // event register read compared with the model, which then clears
    task ev_chk();
        apb(1'b0, EVENT_OFS, 32'h0);
        chk(q, ev_exp);
        ev_exp = 0;
    endtask
    // clean static levels: the controller proves its own outputs
    task pins(input logic a, input logic b, input logic c);
        ca <= a;
        cb <= b;
        cc <= c;
    endtask
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 12'h000; pwdata = 32'h0; jam = 0; arm = 0; ev_exp = 0;
        ca = 0; cb = 0; cc = 0; mn = 1; ax = 0; rl = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (40) @(posedge pclk);
        // powered up locked: no drive, outputs off, yellow flashes
        chk(ext | ret, 0);
        chk(sa | sb, 0);
        y = leds.yellow;
        tog = 0;
        repeat (100) begin
            @(posedge pclk);
            if (leds.yellow !== y) tog++;
            y = leds.yellow;
        end
        chk(tog >= 3, 1);
        apb(1'b1, MASK_OFS, 32'hF);
        pins(1, 1, 0);
        ev_exp |= 1 << EV_UNLOCK;
        wt(opn, 1'b1);
        pins(0, 0, 0);
        ev_exp |= 1 << EV_LOCKED;
        wt(d1, 1'b1);
        repeat (3) @(posedge pclk);
        chk(sa | sb, 1);
        chk(irq, 1);
        ev_chk();
        chk(irq, 0);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(q & 32'h1FF, 32'h014);
        // off-pulses on both channels stay short
        arm <= 1'b1;
        repeat (26000) @(posedge pclk);
        arm <= 1'b0;
        chk(pulses >= 2, 1);
        chk(max_off > 0 && max_off <= TEST_PULSE_CYC, 1);
        chk(max_off <= OFF_LIM_CYC, 1);
        chk(max_skew > 0 && max_skew < DISC_CYC, 1);
        // third input open means lock even with a and b high
        pins(1, 1, 1);
        repeat (20) @(posedge pclk);
        chk(ret, 0);
        // software inhibit holds the lock against an unlock demand
        apb(1'b1, CTRL_OFS, 32'h1);
        pins(1, 1, 0);
        repeat (20) @(posedge pclk);
        chk(ret, 0);
        apb(1'b1, CTRL_OFS, 32'h0);
        ev_exp |= 1 << EV_UNLOCK;
        wt(opn, 1'b1);
        // the open sensor needs its sync stages before the event lands
        repeat (4) @(posedge pclk);
        ev_chk();
        // jammed lock: one retry, then fault; random mask gates irq
        m = 4'($random(seed));
        apb(1'b1, MASK_OFS, {28'h0, m});
        jam <= 1'b1;
        pins(0, 0, 0);
        rises = 0;
        n = 0;
        y = 0;
        while (d2 !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            if (ext === 1'b1 && !y) rises++;
            y = ext;
            n++;
        end
        chk(rises, 2);
        chk(d2, 1);
        chk(sa | sb, 0);
        ev_exp |= (1 << EV_RETRY) | (1 << EV_FAULT);
        repeat (2) @(posedge pclk);
        chk(irq, |(m & 4'hC));
        ev_chk();
        // unmapped place reads zero and ignores writes
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        apb(1'b0, 12'h010, 32'h0);
        chk(q, 0);
        apb(1'b0, MASK_OFS, 32'h0);
        chk(q, {28'h0, m});
        // unchanged inputs never drive the bolt out again
        jam <= 1'b0;
        repeat (100) @(posedge pclk);
        chk(ext, 0);
        pins(1, 1, 0);
        wt(opn, 1'b1);
        pins(0, 0, 0);
        wt(d1, 1'b1);
        chk(d2, 0);
        // start-up on the auxiliary supply alone retracts the bolt
        mn <= 1'b0;
        ax <= 1'b1;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wt(opn, 1'b1);
        chk(ret, 1);
        chk(sa | sb | d2, 0);
        // mechanical release flashes all three until inputs driven
        rl <= 1'b1;
        repeat (30) @(posedge pclk);
        rl <= 1'b0;
        q = leds;
        chk(q == 0 || q == 7, 1);
        repeat (20) @(posedge pclk);
        chk(q ^ leds, 7);
        pins(1, 1, 0);
        repeat (10) @(posedge pclk);
        chk(leds, 3'b010);
        // both supplies at start-up hold the bolt and report a fault
        mn <= 1'b1;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wt(d2, 1'b1);
        chk(ext | ret, 0);
        end_of_test();
    end
endmodule // locking_bolt_control_tb
`default_nettype wire
